// >>> design/asq_conv_timer.sv
// Conversion clock divider and cycle counter for one channel step.
// Assumes start_i is a one-cycle pulse; abort_i stops the step at once.
`timescale 1ns/1ps
`default_nettype none
module asq_conv_timer
	import asq_pkg::*;
#(
	parameter int DIV = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic start_i,
	input wire logic abort_i,
	input wire logic [4:0] cycles_i,
	// Status
	output logic tick_o,
	output logic done_o
);
	logic [7:0] div_r;
	logic [4:0] cnt_r;
	logic run_r;

	// Free-running conversion clock enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= 8'h00;
			tick_o <= 1'b0;
		end else if (div_r == 8'(DIV - 1)) begin
			div_r <= 8'h00;
			tick_o <= 1'b1;
		end else begin
			div_r <= div_r + 8'h01;
			tick_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || abort_i) begin
			run_r <= 1'b0;
			cnt_r <= 5'h00;
			done_o <= 1'b0;
		end else if (start_i) begin
			run_r <= 1'b1;
			cnt_r <= cycles_i;
			done_o <= 1'b0;
		end else if (run_r && tick_o) begin
			cnt_r <= cnt_r - 5'h01;
			done_o <= (cnt_r == 5'h01);
			run_r <= (cnt_r != 5'h01);
		end else begin
			done_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> design/asq_sync.sv
// Two-flop synchroniser for a single asynchronous level.
// Assumes the input comes from a pin outside the clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module asq_sync (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Level
	input wire logic d_i,
	output logic q_o
);
	logic meta_r;

	// Resets high so an idle pull-up pin gives no false edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= 1'b1;
			q_o <= 1'b1;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule
`default_nettype wire

// >>> design/asq_top.sv
// Scan sequencer control of a 10-bit converter: registers, triggers,
// channel walk and status flags.
// Assumes classic Wishbone master on clk_i and an analog core returning
// one result per conversion through conv_res_i.
//
// What this block does
// - Continuous mode repeats the channel range until software stops it.
// - One-time mode converts each channel in range once, then ends.
// - Trigger field: 0 software, 1 timer, 3 external pin, 2 reserved.
// - External source starts a sequence on pin falling edge.
// - Timer source starts a sequence on a timer underflow pulse while idle.
// - Sampling lasts sample field plus two conversion clock cycles.
// - Read-only channel indicator in bits 14..12, reset 0.
// - Busy rises at accepted trigger, falls when the sequence ends or is stopped.
// - Completion while done flag set overwrites result, sets overwrite flag.
// - Writing 1 clears overwrite flag; writing 0 does nothing.
// - Each completion loads the result and sets the done flag.
// - Reading the result register clears the done flag.
// - An overwriting completion also sets the done flag.
// - Done interrupt request when done flag and its enable both set.
// - Overwrite interrupt request when flag and its enable both set.
// - Writing 1 to run bit is the software trigger when enabled.
// - Hardware trigger sets the run bit by itself.
// - Run bit reads 1 during sequence; one-time mode clears it at end.
// - Continuous mode stops only when software writes run bit 0.
// - With enable 0 every trigger is ignored.
// - Justify 1 puts result in bits 15..6, otherwise bits 9..0.
// - Sequence spans first to last channel field; equal means one.
// - Clearing enable blocks triggers only; running conversion continues.
`timescale 1ns/1ps
`default_nettype none
module asq_top
	import asq_pkg::*;
#(
	parameter int DIV = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ASQ_ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Triggers
	input wire logic timer_underflow_i,
	input wire logic external_trigger_pin_n_i,
	// Analog core
	input wire asq_res_s conv_res_i,
	output logic [2:0] analog_input_channel_o,
	output logic sample_o,
	// Interrupt requests
	output logic done_irq_o,
	output logic ovw_irq_o
);

	// ========================================================
	// Register state
	asq_cfg_s cfg_r;
	logic en_r;
	logic run_r;
	logic die_r;
	logic oie_r;
	logic done_r;
	logic ovw_r;
	logic busy_r;
	logic [2:0] ch_r;
	logic [15:0] result_r;
	asq_state_e state_r;

	// ========================================================
	// Bus decode
	logic req;
	logic wr;
	logic rd;
	logic lo_lane;
	logic hi_lane;

	function automatic logic hit(input logic [ASQ_ADDR_W-1:0] a,
		input logic [15:0] ofs);
		hit = (a[ASQ_ADDR_W-1:2] == ofs[15:2]) && (a[1:0] == ofs[1:0]);
	endfunction

	assign req = cyc_i && stb_i && !ack_o;
	assign wr = req && we_i;
	assign rd = req && !we_i;
	// 16-bit registers live in the low half; byte lanes steer writes
	assign lo_lane = sel_i[0];
	assign hi_lane = sel_i[1];

	logic wr_trg;
	logic wr_ctl;
	logic rd_res;
	assign wr_trg = wr && hit(adr_i, ASQ_OFS_TRIG);
	assign wr_ctl = wr && hit(adr_i, ASQ_OFS_CTL);
	assign rd_res = rd && hit(adr_i, ASQ_OFS_RESULT);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	// ========================================================
	// Trigger detection
	logic ext_s;
	logic ext_d_r;
	logic ext_fall;
	logic sw_trig;
	logic hw_trig;
	logic trig;

	asq_sync u_ext_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(external_trigger_pin_n_i),
		.q_o(ext_s)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_d_r <= 1'b1;
		end else begin
			ext_d_r <= ext_s;
		end
	end

	assign ext_fall = ext_d_r && !ext_s;
	assign sw_trig = wr_ctl && lo_lane && dat_i[ASQ_CTL_RUN]
		&& cfg_r.tsrc == ASQ_TS_SOFT;
	always_comb begin
		unique case (cfg_r.tsrc)
			ASQ_TS_TIMER: hw_trig = timer_underflow_i;
			ASQ_TS_EXT: hw_trig = ext_fall;
			default: hw_trig = 1'b0;
		endcase
	end
	// Only an idle sequencer takes a new trigger
	// A stop written in the same cycle beats a hardware trigger
	assign trig = en_r && state_r == ASQ_IDLE && !(wr_ctl && lo_lane
		&& !dat_i[ASQ_CTL_RUN]) && (sw_trig || hw_trig);

	// ========================================================
	// Configuration register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r <= '{last_ch: 3'h0, first_ch: 3'h0, justify: 1'b0,
				mode: 1'b0, tsrc: ASQ_TS_SOFT, sample: ASQ_RST_SAMPLE};
		end else if (wr_trg) begin
			if (lo_lane) begin
				cfg_r.sample <= dat_i[ASQ_TRG_ST_LO +: 3];
				cfg_r.tsrc <= asq_tsrc_e'(dat_i[ASQ_TRG_TS_LO +: 2]);
				cfg_r.mode <= dat_i[ASQ_TRG_MODE];
				cfg_r.justify <= dat_i[ASQ_TRG_JUST];
			end
			if (hi_lane) begin
				cfg_r.first_ch <= dat_i[ASQ_TRG_FIRST_LO +: 3];
				cfg_r.last_ch <= dat_i[ASQ_TRG_LAST_LO +: 3];
			end
		end
	end

	// Enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_r <= 1'b0;
			die_r <= 1'b0;
			oie_r <= 1'b0;
		end else if (wr_ctl && lo_lane) begin
			en_r <= dat_i[ASQ_CTL_EN];
			die_r <= dat_i[ASQ_CTL_DIE];
			oie_r <= dat_i[ASQ_CTL_OIE];
		end
	end

	// ========================================================
	// Sequencer
	logic step_start;
	logic step_done;
	logic tick;
	logic seq_stop;
	logic last_step;
	logic [4:0] step_cycles;

	assign seq_stop = wr_ctl && lo_lane && !dat_i[ASQ_CTL_RUN];
	assign last_step = ch_r == cfg_r.last_ch;
	assign step_cycles = 5'({2'b00, cfg_r.sample} + ASQ_SAMPLE_BASE);

	asq_conv_timer #(
		.DIV(DIV)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(step_start),
		.abort_i(seq_stop),
		.cycles_i(state_r == ASQ_SAMPLE ? 5'(ASQ_CONV_CYC)
			: step_cycles),
		.tick_o(tick),
		.done_o(step_done)
	);

	// Conversion phase ends when the core result arrives
	logic conv_end;
	assign conv_end = state_r == ASQ_CONVERT && conv_res_i.valid;
	assign step_start = trig || (state_r == ASQ_SAMPLE && step_done)
		|| (conv_end && !(last_step && !cfg_r.mode));

	always_ff @(posedge clk_i) begin
		if (rst_i || seq_stop) begin
			state_r <= ASQ_IDLE;
		end else begin
			unique case (state_r)
				ASQ_IDLE: if (trig) begin
					state_r <= ASQ_SAMPLE;
				end
				ASQ_SAMPLE: if (step_done) begin
					state_r <= ASQ_CONVERT;
				end
				ASQ_CONVERT: if (conv_end) begin
					state_r <= (last_step && !cfg_r.mode) ? ASQ_IDLE
						: ASQ_SAMPLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ch_r <= 3'h0;
		end else if (trig) begin
			ch_r <= cfg_r.first_ch;
		end else if (conv_end) begin
			ch_r <= last_step ? cfg_r.first_ch : ch_r + 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (trig) begin
			run_r <= 1'b1;
			busy_r <= 1'b1;
		end else if (seq_stop
			|| (conv_end && last_step && !cfg_r.mode)) begin
			run_r <= 1'b0;
			busy_r <= 1'b0;
		end
	end

	// ========================================================
	// Result and flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_r <= 16'h0000;
		end else if (conv_end) begin
			result_r <= cfg_r.justify ? {conv_res_i.data, 6'h00}
				: {6'h00, conv_res_i.data};
		end
	end

	// Completion wins over a read in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_r <= 1'b0;
		end else if (conv_end) begin
			done_r <= 1'b1;
		end else if (rd_res) begin
			done_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovw_r <= 1'b0;
		end else if (conv_end && done_r) begin
			ovw_r <= 1'b1;
		end else if (wr_ctl && hi_lane && dat_i[ASQ_CTL_OVW]) begin
			ovw_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_irq_o <= 1'b0;
			ovw_irq_o <= 1'b0;
		end else begin
			// Next-state set terms so requests rise with flags; overwrite request drops one cycle after its flag clears
			done_irq_o <= die_r && (conv_end || (done_r && !rd_res));
			ovw_irq_o <= oie_r && (ovw_r || (conv_end && done_r));
		end
	end

	// ========================================================
	// Analog side and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			analog_input_channel_o <= 3'h0;
			sample_o <= 1'b0;
		end else begin
			analog_input_channel_o <= ch_r;
			sample_o <= state_r == ASQ_SAMPLE;
		end
	end

	logic [15:0] ctl_rd;
	logic [15:0] trg_rd;
	always_comb begin
		ctl_rd = 16'h0000;
		ctl_rd[ASQ_CTL_CH_LO +: 3] = ch_r;
		ctl_rd[ASQ_CTL_BUSY] = busy_r;
		ctl_rd[ASQ_CTL_OVW] = ovw_r;
		ctl_rd[ASQ_CTL_DONE] = done_r;
		ctl_rd[ASQ_CTL_OIE] = oie_r;
		ctl_rd[ASQ_CTL_DIE] = die_r;
		ctl_rd[ASQ_CTL_RUN] = run_r;
		ctl_rd[ASQ_CTL_EN] = en_r;
		trg_rd = {2'b00, cfg_r.last_ch, cfg_r.first_ch, cfg_r.justify,
			cfg_r.mode, cfg_r.tsrc, 1'b0, cfg_r.sample};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (rd) begin
			if (hit(adr_i, ASQ_OFS_RESULT)) begin
				dat_o <= {16'h0000, result_r};
			end else if (hit(adr_i, ASQ_OFS_TRIG)) begin
				dat_o <= {16'h0000, trg_rd};
			end else if (hit(adr_i, ASQ_OFS_CTL)) begin
				dat_o <= {16'h0000, ctl_rd};
			end else begin
				dat_o <= 32'h0000_0000;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/asq_checker.sv
// Concurrent checks on the scan sequencer control ports.
// Assumes binding to asq_top; DIV is handed on from the instance.
`timescale 1ns/1ps
`default_nettype none
module asq_checker
	import asq_pkg::*;
#(
	parameter int DIV = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ASQ_ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Core and requests
	input wire asq_res_s conv_res_i,
	input wire logic [2:0] analog_input_channel_o,
	input wire logic sample_o,
	input wire logic done_irq_o,
	input wire logic ovw_irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ========================================================
	// Shadow of enables and sample field
	logic die_r;
	logic oie_r;
	logic [2:0] st_r;
	logic [7:0] scnt_r;
	wire wr_ack = ack_o && we_i && sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			die_r <= 1'b0;
			oie_r <= 1'b0;
		end else if (wr_ack && adr_i == ASQ_OFS_CTL) begin
			die_r <= dat_i[ASQ_CTL_DIE];
			oie_r <= dat_i[ASQ_CTL_OIE];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			st_r <= ASQ_RST_SAMPLE;
		else if (wr_ack && adr_i == ASQ_OFS_TRIG)
			st_r <= dat_i[2:0];
	end

	// Divider phase may shift the start by up to one tick
	always_ff @(posedge clk_i) begin
		if (rst_i || !sample_o)
			scnt_r <= 8'h0;
		else
			scnt_r <= scnt_r + 8'h1;
	end

	// ========================================================
	// Assertions
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	ack_timely_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing one cycle after request");
	done_mask_a: assert property (!die_r && $past(!die_r) |-> !done_irq_o)
		else $error("done request while its enable is off");
	ovw_mask_a: assert property (!oie_r && $past(!oie_r) |-> !ovw_irq_o)
		else $error("overwrite request while its enable is off");
	rd_clear_a: assert property (ack_o && cyc_i && !we_i &&
		adr_i == ASQ_OFS_RESULT && !conv_res_i.valid &&
		!$past(conv_res_i.valid) |=> !done_irq_o)
		else $error("result read left done request up");
	rsvd_zero_a: assert property (ack_o && !we_i &&
		adr_i == ASQ_OFS_CTL |-> (dat_o & 32'hffff88cc) == 32'h0)
		else $error("reserved status bits read nonzero");
	sample_len_a: assert property ($fell(sample_o) |->
		int'(scnt_r) > (int'(st_r) + 1) * DIV &&
		int'(scnt_r) <= (int'(st_r) + 2) * DIV + 1)
		else $error("sampling length off");
	chan_hold_a: assert property (sample_o && $past(sample_o) &&
		$past(sample_o, 2) |-> $stable(analog_input_channel_o))
		else $error("channel changed during sampling");
endmodule

bind asq_top asq_checker #(.DIV(DIV)) asq_checker_inst (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.cyc_i(cyc_i),
	.stb_i(stb_i),
	.we_i(we_i),
	.adr_i(adr_i),
	.sel_i(sel_i),
	.dat_i(dat_i),
	.dat_o(dat_o),
	.ack_o(ack_o),
	.conv_res_i(conv_res_i),
	.analog_input_channel_o(analog_input_channel_o),
	.sample_o(sample_o),
	.done_irq_o(done_irq_o),
	.ovw_irq_o(ovw_irq_o)
);
`default_nettype wire

// >>> dv/asq_top_tb.sv
// Self-checking bench for the scan sequencer control block.
// Assumes the checker is bound to asq_top; DIV is 2 in simulation.
`timescale 1ns/1ps
`default_nettype none
module asq_top_tb
	import asq_pkg::*;
;
	logic clk_i;
	logic rst_i;
	logic cyc_i;
	logic stb_i;
	logic we_i;
	logic [15:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic [31:0] q;
	logic ack_o;
	logic timer_underflow_i;
	logic external_trigger_pin_n_i;
	asq_res_s conv_res_i;
	logic [2:0] analog_input_channel_o;
	logic sample_o;
	logic done_irq_o;
	logic ovw_irq_o;
	int fail_count = 0;
	int checked = 0;

	asq_top #(.DIV(2)) asq_top_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.timer_underflow_i(timer_underflow_i),
		.external_trigger_pin_n_i(external_trigger_pin_n_i),
		.conv_res_i(conv_res_i),
		.analog_input_channel_o(analog_input_channel_o),
		.sample_o(sample_o),
		.done_irq_o(done_irq_o),
		.ovw_irq_o(ovw_irq_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ========================================================
	// Shared tasks
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// Classic cycle; read data lands in q
	task automatic wb(input int w, input int a, input int d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w[0];
		adr_i <= a[15:0];
		dat_i <= {16'h0, d[15:0]};
		sel_i <= 4'h3;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 50) fail_count++;
	endtask

	task automatic samp(input int ch);
		int n;
		n = 0;
		while (sample_o !== 1'b1 && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		@(posedge clk_i);
		chk({29'h0, analog_input_channel_o}, ch);
		while (sample_o !== 1'b0 && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 300) fail_count++;
	endtask

	task automatic give(input logic [9:0] d);
		@(posedge clk_i);
		conv_res_i <= {1'b1, d};
		@(posedge clk_i);
		conv_res_i <= '0;
	endtask

	task automatic fall();
		@(posedge clk_i);
		external_trigger_pin_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		external_trigger_pin_n_i <= 1'b1;
	endtask

	// ========================================================
	// Scenarios
	task automatic t_reset();
		wb(0, ASQ_OFS_CTL, 0);
		chk(q, 32'h0);
		wb(0, ASQ_OFS_TRIG, 0);
		chk(q, 32'h0007);
		wb(1, ASQ_OFS_RESULT, 16'hffff);
		wb(0, ASQ_OFS_RESULT, 0);
		chk(q, 32'h0);
		wb(0, 16'h5386, 0);
		chk(q, 32'h0);
	endtask

	// Long sampling leaves room to read between channels
	task automatic t_once();
		wb(1, ASQ_OFS_TRIG, 16'h2207);
		wb(1, ASQ_OFS_CTL, 16'h0011);
		wb(1, ASQ_OFS_CTL, 16'h0013);
		wb(0, ASQ_OFS_CTL, 0);
		chk(q & 32'h0fff, 32'h0413);
		for (int c = 2; c <= 4; c++) begin
			samp(c[2:0]);
			give(10'h3c0 + c[9:0]);
			repeat (2) @(posedge clk_i);
			chk({31'h0, done_irq_o}, 32'h1);
			wb(0, ASQ_OFS_RESULT, 0);
			chk(q, 32'h3c0 + c);
			wb(0, ASQ_OFS_CTL, 0);
			chk(q & 32'h0300, 32'h0);
		end
		repeat (4) @(posedge clk_i);
		wb(0, ASQ_OFS_CTL, 0);
		chk(q & 32'h0fff, 32'h0011);
	endtask

	task automatic t_cont();
		wb(1, ASQ_OFS_TRIG, 16'h36d0);
		wb(1, ASQ_OFS_CTL, 16'h0021);
		@(posedge clk_i);
		timer_underflow_i <= 1'b1;
		@(posedge clk_i);
		timer_underflow_i <= 1'b0;
		samp(6);
		give(10'h155);
		samp(6);
		give(10'h2aa);
		samp(6);
		chk({31'h0, ovw_irq_o}, 32'h1);
		wb(1, ASQ_OFS_CTL, 16'h0022);
		repeat (2) @(posedge clk_i);
		chk({31'h0, ovw_irq_o}, 32'h1);
		wb(0, ASQ_OFS_CTL, 0);
		chk(q, 32'h6722);
		wb(0, ASQ_OFS_RESULT, 0);
		chk(q, 32'haa80);
		wb(1, ASQ_OFS_CTL, 16'h0221);
		wb(0, ASQ_OFS_CTL, 0);
		chk(q & 32'h0fff, 32'h0021);
		chk({31'h0, ovw_irq_o}, 32'h0);
	endtask

	task automatic t_ext();
		wb(1, ASQ_OFS_TRIG, 16'h0037);
		wb(1, ASQ_OFS_CTL, 16'h0000);
		fall();
		repeat (20) @(posedge clk_i);
		wb(0, ASQ_OFS_CTL, 0);
		chk(q & 32'h0fff, 32'h0000);
		wb(1, ASQ_OFS_CTL, 16'h0001);
		fall();
		samp(0);
		give(10'h3ff);
		repeat (3) @(posedge clk_i);
		wb(0, ASQ_OFS_CTL, 0);
		chk(q & 32'h0fff, 32'h0101);
		wb(0, ASQ_OFS_RESULT, 0);
		chk(q, 32'h03ff);
	endtask

	// ========================================================
	// Main sequence and watchdog
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 16'h0;
		sel_i = 4'h0;
		dat_i = 32'h0;
		timer_underflow_i = 1'b0;
		external_trigger_pin_n_i = 1'b1;
		conv_res_i = '0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_once();
		t_cont();
		t_ext();
		report_and_stop();
	end

	initial begin
		#100000;
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire

// >>> include/asq_pkg.sv
// Package for the scan sequencer control block: offsets, fields, resets,
// states and carrier structs.
// Assumes a 32-bit classic Wishbone slave with halfword-aligned registers.
package asq_pkg;

	// ========================================================
	// Register map (byte addresses)
	localparam logic [15:0] ASQ_OFS_RESULT = 16'h5380;
	localparam logic [15:0] ASQ_OFS_TRIG = 16'h5382;
	localparam logic [15:0] ASQ_OFS_CTL = 16'h5384;
	localparam int ASQ_ADDR_W = 16;

	// ========================================================
	// Control/status field positions
	localparam int ASQ_CTL_EN = 0;
	localparam int ASQ_CTL_RUN = 1;
	localparam int ASQ_CTL_DIE = 4;
	localparam int ASQ_CTL_OIE = 5;
	localparam int ASQ_CTL_DONE = 8;
	localparam int ASQ_CTL_OVW = 9;
	localparam int ASQ_CTL_BUSY = 10;
	localparam int ASQ_CTL_CH_LO = 12;

	// ========================================================
	// Trigger/channel select field positions
	localparam int ASQ_TRG_ST_LO = 0;
	localparam int ASQ_TRG_TS_LO = 4;
	localparam int ASQ_TRG_MODE = 6;
	localparam int ASQ_TRG_JUST = 7;
	localparam int ASQ_TRG_FIRST_LO = 8;
	localparam int ASQ_TRG_LAST_LO = 11;

	// ========================================================
	// Reset values and counts
	localparam logic [2:0] ASQ_RST_SAMPLE = 3'h7;
	localparam logic [1:0] ASQ_RST_TSRC = 2'h0;
	localparam logic [3:0] ASQ_SAMPLE_BASE = 4'h2;
	localparam int ASQ_CONV_CYC = 11;

	typedef enum logic [1:0] {
		ASQ_TS_SOFT = 2'h0,
		ASQ_TS_TIMER = 2'h1,
		ASQ_TS_RSVD = 2'h2,
		ASQ_TS_EXT = 2'h3
	} asq_tsrc_e;

	typedef enum logic [2:0] {
		ASQ_IDLE = 3'b001,
		ASQ_SAMPLE = 3'b010,
		ASQ_CONVERT = 3'b100
	} asq_state_e;

	// Sequencer configuration
	typedef struct packed {
		logic [2:0] last_ch;
		logic [2:0] first_ch;
		logic justify;
		logic mode;
		asq_tsrc_e tsrc;
		logic [2:0] sample;
	} asq_cfg_s;

	// Result delivery from the converter core
	typedef struct packed {
		logic valid;
		logic [9:0] data;
	} asq_res_s;

endpackage
